// >>> hw/dgr_dac_regs.sv
// converter data word, gain and update control registers
//
// Notes on behaviour
// - buffer gain field in bits 1:0 resets to 1, codes 0/1/2 give gain 2, 2.4 and 3.
// - the low data byte is an 8-bit read-write register resetting to zero.
// - the high data byte is an 8-bit read-write register resetting to zero.
// - writing the low data byte blocks update triggers.
// - writing the high data byte lifts that block again.
// - when not blocked, a 3-bit source picks every clock, a timer overflow or a logic rise.
// - the justify bit reads the word right-justified at 0 and left-justified at 1.
`timescale 1ns/100ps
module dgr_dac_regs
  import dgr_pkg::*;
#(
  parameter int DATA_W = 12
)
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // special function register access
  input wire dgr_pkg::dgr_sfr_req_s sfr_req_in,
  output logic [7:0] sfr_rdata_out,
  // update trigger sources
  input wire dgr_pkg::dgr_trig_s trig_in,
  // analog side controls
  output logic [1:0] buffer_gain_select_out,
  output logic [DATA_W-1:0] dac_code_out,
  output logic update_inhibit_out
);
  import dgr_pkg::*;

  logic [7:0] data_low_reg;
  logic [7:0] data_high_reg;
  logic [1:0] gain_reg;
  logic [2:0] source_reg;
  logic justify_reg;
  logic inhibit_reg;
  logic [DATA_W-1:0] code_reg;
  logic [7:0] rdata_reg;
  logic [DATA_W-1:0] code_next;
  logic trig_event;
  logic update_now;
  logic wr_low;
  logic wr_high;
  logic wr_gain;
  logic wr_cfg;

  assign wr_low = sfr_req_in.wr && (sfr_req_in.addr == DGR_ADDR_DATA_LOW);
  assign wr_high = sfr_req_in.wr && (sfr_req_in.addr == DGR_ADDR_DATA_HIGH);
  assign wr_gain = sfr_req_in.wr && (sfr_req_in.addr == DGR_ADDR_GAIN_CFG);
  assign wr_cfg = sfr_req_in.wr && (sfr_req_in.addr == DGR_ADDR_UPDATE_CFG);

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      data_low_reg <= DGR_DATA_RST;
    else if (wr_low)
      data_low_reg <= sfr_req_in.wdata;
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      data_high_reg <= DGR_DATA_RST;
    else if (wr_high)
      data_high_reg <= sfr_req_in.wdata;
  end

  // buffer gain field, reserved bits dropped
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      gain_reg <= DGR_GAIN_RST;
    else if (wr_gain)
      gain_reg <= sfr_req_in.wdata[DGR_GAIN_LSB +: DGR_GAIN_W];
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      source_reg <= DGR_SRC_RST;
      justify_reg <= DGR_JUST_RST;
    end
    else if (wr_cfg)
    begin
      source_reg <= sfr_req_in.wdata[DGR_SRC_LSB +: DGR_SRC_W];
      justify_reg <= sfr_req_in.wdata[DGR_JUST_BIT];
    end
  end

  // inhibit set by low write, lifted by high write
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      inhibit_reg <= 1'b0;
    else if (wr_low)
      inhibit_reg <= 1'b1;
    else if (wr_high)
      inhibit_reg <= 1'b0;
  end

  dgr_trigger_select u_trig (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .source_sel_in(source_reg),
    .trig_in(trig_in),
    .event_out(trig_event)
  );

  // a low write blocks its own cycle too, so half a word never lands
  // event gated by inhibit
  assign update_now = trig_event && !inhibit_reg && !wr_low;

  always_comb
  begin
    if (justify_reg == DGR_ALIGN_HIGH)
      code_next = DATA_W'({data_high_reg, data_low_reg} >> (16 - DATA_W));
    else
      code_next = DATA_W'({data_high_reg, data_low_reg});
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      code_reg <= '0;
    else if (update_now)
      code_reg <= code_next;
  end

  // read data registered, one cycle after the read strobe
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rdata_reg <= 8'h00;
    else if (sfr_req_in.rd)
    begin
      unique case (sfr_req_in.addr)
        DGR_ADDR_DATA_LOW: rdata_reg <= data_low_reg;
        DGR_ADDR_DATA_HIGH: rdata_reg <= data_high_reg;
        DGR_ADDR_GAIN_CFG: rdata_reg <= {6'h00, gain_reg};
        DGR_ADDR_UPDATE_CFG: rdata_reg <= {2'h0, justify_reg, 2'h0, source_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  assign sfr_rdata_out = rdata_reg;
  assign buffer_gain_select_out = gain_reg;
  assign dac_code_out = code_reg;
  assign update_inhibit_out = inhibit_reg;

  a_gain_write_takes: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    wr_gain |=> buffer_gain_select_out == $past(sfr_req_in.wdata[1:0]))
    else $error("gain field did not take the written value");

  a_low_byte_holds: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    wr_low ##1 (!wr_low)[*2] |-> data_low_reg == $past(sfr_req_in.wdata, 2))
    else $error("low byte lost its written value");

  a_high_byte_holds: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    wr_high |=> data_high_reg == $past(sfr_req_in.wdata))
    else $error("high byte did not take the written value");

  a_low_blocks_update: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    wr_low ##1 (!wr_high)[*3] |-> $stable(dac_code_out) && update_inhibit_out)
    else $error("output updated while low byte write pending");

  a_high_lifts_block: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    wr_high && !wr_low |=> !update_inhibit_out)
    else $error("high byte write did not lift the block");

  a_every_clock_src: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    source_reg == DGR_SRC_EVERY_CLOCK && !inhibit_reg && !wr_low |=> dac_code_out == $past(code_next))
    else $error("every-clock source failed to update");

  a_align_low: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    update_now && !justify_reg |=> dac_code_out[7:0] == $past(data_low_reg))
    else $error("right-justified word misaligned");

  a_update_one_cycle: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    !update_now |=> $stable(dac_code_out))
    else $error("output code changed without an update event");
endmodule

// >>> hw/dgr_pkg.sv
// shared constants and types for the converter data and gain registers
package dgr_pkg;
  // special function register addresses
  localparam logic [7:0] DGR_ADDR_DATA_LOW = 8'h8D;
  localparam logic [7:0] DGR_ADDR_DATA_HIGH = 8'h8E;
  localparam logic [7:0] DGR_ADDR_UPDATE_CFG = 8'h9A;
  localparam logic [7:0] DGR_ADDR_GAIN_CFG = 8'h9C;
  // reset values
  localparam logic [7:0] DGR_DATA_RST = 8'h00;
  localparam logic [1:0] DGR_GAIN_RST = 2'h1;
  localparam logic [2:0] DGR_SRC_RST = 3'h0;
  localparam logic DGR_JUST_RST = 1'b0;
  // field positions in the update config register
  localparam int DGR_JUST_BIT = 5;
  localparam int DGR_SRC_LSB = 0;
  localparam int DGR_SRC_W = 3;
  // field positions in the gain config register
  localparam int DGR_GAIN_LSB = 0;
  localparam int DGR_GAIN_W = 2;
  // gain codes
  localparam logic [1:0] DGR_GAIN_TWO = 2'h0;
  localparam logic [1:0] DGR_GAIN_TWO_POINT_FOUR = 2'h1;
  localparam logic [1:0] DGR_GAIN_THREE = 2'h2;
  // update source groups
  localparam logic [2:0] DGR_SRC_EVERY_CLOCK = 3'h0;
  localparam logic [2:0] DGR_SRC_TIMER_FIRST = 3'h1;
  localparam logic [2:0] DGR_SRC_LOGIC_FIRST = 3'h4;
  localparam int DGR_NUM_TIMERS = 3;
  localparam int DGR_NUM_LOGIC = 4;
  // justification codes
  localparam logic DGR_ALIGN_LOW = 1'b0;
  localparam logic DGR_ALIGN_HIGH = 1'b1;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } dgr_sfr_req_s;

  typedef struct packed {
    logic [DGR_NUM_TIMERS-1:0] timer_ovf;
    logic [DGR_NUM_LOGIC-1:0] logic_out;
  } dgr_trig_s;
endpackage

// >>> hw/dgr_trigger_select.sv
// update trigger source selection with edge detect on logic outputs
`timescale 1ns/100ps
module dgr_trigger_select
  import dgr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // source select and raw trigger inputs
  input wire logic [2:0] source_sel_in,
  input wire dgr_pkg::dgr_trig_s trig_in,
  // selected event: held high for source 0, timer overflow level for 1-3, one-cycle logic rise pulse for 4-7
  output logic event_out
);
  import dgr_pkg::*;

  logic [DGR_NUM_LOGIC-1:0] logic_prev_reg;
  logic [DGR_NUM_LOGIC-1:0] logic_rise;
  logic [2:0] timer_idx;
  logic [2:0] logic_idx;

  // previous level kept per logic output for rising edge detection
  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      logic_prev_reg <= '0;
    else
      logic_prev_reg <= trig_in.logic_out;
  end

  genvar g;
  generate
    for (g = 0; g < DGR_NUM_LOGIC; g++)
    begin : g_rise
      assign logic_rise[g] = trig_in.logic_out[g] & ~logic_prev_reg[g];
    end
  endgenerate

  assign timer_idx = source_sel_in - DGR_SRC_TIMER_FIRST;
  assign logic_idx = source_sel_in - DGR_SRC_LOGIC_FIRST;

  always_comb
  begin
    if (source_sel_in == DGR_SRC_EVERY_CLOCK)
      event_out = 1'b1;
    else if (source_sel_in < DGR_SRC_LOGIC_FIRST)
      event_out = trig_in.timer_ovf[timer_idx[1:0]];
    else
      event_out = logic_rise[logic_idx[1:0]];
  end
endmodule

// >>> tb/dgr_bench.sv
// self-checking bench for the converter data and gain registers
`timescale 1ns/100ps
module dac_data_gain_registers_bench;
  import dgr_pkg::*;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  dgr_sfr_req_s req = '0;
  dgr_trig_s trig = '0;
  logic [7:0] rdata;
  logic [1:0] gain;
  logic [11:0] code;
  logic inhibit;
  logic [31:0] seed = 32'h3D;
  int n_mismatch = 0;
  int compares = 0;
  logic [7:0] lo, hi, pl, ph;
  logic j, pj;
  logic [2:0] src;
  logic [11:0] old;

  dgr_dac_regs #(.DATA_W(12)) dut (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .sfr_req_in(req), .sfr_rdata_out(rdata), .trig_in(trig),
    .buffer_gain_select_out(gain), .dac_code_out(code), .update_inhibit_out(inhibit));

  always #12.5 ref_clk_in = ~ref_clk_in;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [11:0] word(input logic [7:0] h, input logic [7:0] l, input logic a);
    return a ? {h, l[7:4]} : {h[3:0], l};
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick;
    @(negedge ref_clk_in);
  endtask

  // idle cycle at the end so a following call never re-raises wr in the same step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    tick();
    req.wr = 1'b0;
    tick();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req.addr = a;
    req.rd = 1'b1;
    tick();
    req.rd = 1'b0;
    check("read data", rdata, exp);
    tick();
  endtask

  // low then high back to back, as software is meant to load the word
  task automatic load(input logic [7:0] l, input logic [7:0] h);
    req.addr = DGR_ADDR_DATA_LOW;
    req.wdata = l;
    req.wr = 1'b1;
    tick();
    check("inhibit low", inhibit, 1'b1);
    req.addr = DGR_ADDR_DATA_HIGH;
    req.wdata = h;
    tick();
    req.wr = 1'b0;
    check("inhibit high", inhibit, 1'b0);
    check("code held", code, old);
  endtask

  task automatic complete_run;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // whole sequence is under two hundred cycles
  initial
  begin
    #(25 * 3000);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    repeat (2) tick();
    nrst_in = 1'b1;
    check("gain reset", gain, DGR_GAIN_RST);
    check("code reset", code, 16'h0000);
    check("inhibit reset", inhibit, 1'b0);
    rd(DGR_ADDR_DATA_LOW, 8'h00);
    rd(DGR_ADDR_DATA_HIGH, 8'h00);
    rd(DGR_ADDR_GAIN_CFG, 8'h01);
    rd(8'h55, 8'h00);
    for (int g = 0; g < 4; g++)
    begin
      wr(DGR_ADDR_GAIN_CFG, {6'h3F, g[1:0]});
      check("gain", gain, g[1:0]);
      rd(DGR_ADDR_GAIN_CFG, {6'h00, g[1:0]});
    end
    // leave buffer gain on the code for gain 2.4, its reset value
    wr(DGR_ADDR_GAIN_CFG, {6'h00, DGR_GAIN_TWO_POINT_FOUR});
    check("gain matched", gain, DGR_GAIN_TWO_POINT_FOUR);
    pl = 8'h00;
    ph = 8'h00;
    pj = 1'b0;
    // every source code twice, random data and justification
    for (int i = 0; i < 16; i++)
    begin
      seed = xs(seed);
      lo = seed[7:0];
      hi = seed[15:8];
      j = seed[16];
      src = i[2:0];
      wr(DGR_ADDR_UPDATE_CFG, {2'h0, j, 2'h0, src});
      old = word(ph, pl, src == 3'h0 ? j : pj);
      check("code before", code, old);
      load(lo, hi);
      if (src inside {[3'h1:3'h3]})
        trig.timer_ovf[src - 3'h1] = 1'b1;
      if (src >= 3'h4)
        trig.logic_out[src - 3'h4] = 1'b1;
      tick();
      trig = '0;
      check("code new", code, word(hi, lo, j));
      rd(DGR_ADDR_DATA_LOW, lo);
      rd(DGR_ADDR_DATA_HIGH, hi);
      pl = lo;
      ph = hi;
      pj = j;
    end
    // a trigger arriving while the word is half written is dropped
    // last loop pass left source 7 selected, so the last logic output is the live trigger
    old = code;
    wr(DGR_ADDR_DATA_LOW, 8'hA5);
    trig.logic_out[DGR_NUM_LOGIC - 1] = 1'b1;
    tick();
    trig = '0;
    tick();
    check("code blocked", code, old);
    wr(DGR_ADDR_DATA_HIGH, 8'h3C);
    check("inhibit lifted", inhibit, 1'b0);
    check("code waits", code, old);
    trig.logic_out[DGR_NUM_LOGIC - 1] = 1'b1;
    tick();
    trig = '0;
    check("code after", code, word(8'h3C, 8'hA5, pj));
    complete_run();
  end
endmodule
